// ---- logic/btse_decode.sv ----
// btse_decode.sv: combinational field decode and operand addressing.
// assumes: instruction word and bank select are stable for the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "btse_map.svh"

module btse_decode (
    input  wire logic [15:0]         instr,
    input  wire logic [3:0]          bank_select_register,
    input  wire logic                ext_set_en,
    output var btse_pkg::btse_dec_t  dec,
    output var btse_pkg::btse_addr_t addr
);

    wire logic [3:0] opcode;
    wire logic       small_addr;

    assign opcode = instr[`BTSE_OP_MSB:`BTSE_OP_LSB];
    assign dec.is_clear  = (opcode == `BTSE_OP_CLEAR);
    assign dec.is_set    = (opcode == `BTSE_OP_SET);
    assign dec.bit_sel   = instr[`BTSE_BIT_MSB:`BTSE_BIT_LSB];
    assign dec.bank_ctl  = instr[`BTSE_BANK_CTL_POS];
    assign dec.file_addr = instr[`BTSE_FILE_MSB:`BTSE_FILE_LSB];

    assign small_addr = (dec.file_addr <= `BTSE_IDX_LIMIT);

    // indexed mode overrides the access bank only for the low offsets
    assign addr.mode = dec.bank_ctl ? btse_pkg::BTSE_MODE_BANKED
        : (ext_set_en && small_addr) ? btse_pkg::BTSE_MODE_INDEXED
        : btse_pkg::BTSE_MODE_ACCESS;
    assign addr.bank   = dec.bank_ctl ? bank_select_register : 4'h0;
    assign addr.offset = dec.file_addr;

endmodule : btse_decode
`default_nettype wire

// ---- logic/btse_exec.sv ----
// btse_exec.sv: execution sequencer of the bit-test-skip instructions.
// assumes: q1_en pulses once per instruction cycle on its first quarter;
// instr is valid from that pulse; file_data is valid by the last quarter.
`timescale 1ns/1ps
`default_nettype none
`include "btse_map.svh"

// Overview of operation
// - opcode 1011 is skip-if-clear and skips when the tested bit is zero.
// - a taken skip discards the prefetched word and runs one nop cycle for a one-word victim.
// - with bank-control zero the operand lies in the access bank unless indexed mode applies.
// - with bank-control one the bank select register gives the bank.
// - bank-control zero, extended set on and address up to 5Fh is indexed.
// - skipping a two-word instruction costs two nop cycles.
// - skip-if-set skips when the tested bit is one.
// - opcode 1010 is skip-if-set with the same field layout.
module btse_exec (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 q1_en,
    input  wire logic [15:0]          instr,
    input  wire logic                 instr_valid,
    input  wire logic [3:0]           bank_select_register,
    input  wire logic                 ext_set_en,
    input  wire logic [7:0]           file_data,
    input  wire logic                 next_two_word,
    output var btse_pkg::btse_addr_t  file_addr,
    output logic                      file_rd,
    output logic                      busy,
    output logic                      discard_prefetch,
    output logic                      nop_cycle,
    output logic                      skip_taken,
    output logic [1:0]                cycles_used
);

    // ------------------------------------------------------------
    // quarter-cycle tracking
    // ------------------------------------------------------------
    logic [1:0] q_reg;
    logic [1:0] q_next;
    wire  logic q4_now;

    assign q_next = q1_en ? 2'h0 : q_reg + 2'h1;
    assign q4_now = (q_reg == `BTSE_Q_LAST);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) q_reg <= `BTSE_Q_LAST;
        else       q_reg <= q_next;
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    btse_pkg::btse_dec_t  dec;
    btse_pkg::btse_addr_t addr;

    btse_decode u_decode (
        .instr                (instr),
        .bank_select_register (bank_select_register),
        .ext_set_en           (ext_set_en),
        .dec                  (dec),
        .addr                 (addr)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BTSE_IDLE,
        BTSE_TEST,
        BTSE_NOP
    } btse_state_t;

    btse_state_t          state_reg;
    btse_state_t          state_next;
    btse_pkg::btse_dec_t  dec_reg;
    btse_pkg::btse_addr_t addr_reg;
    logic [1:0]           nop_left_reg;
    logic [1:0]           nop_left_next;
    logic [1:0]           cyc_reg;
    logic [1:0]           cyc_next;
    logic                 skip_reg;
    logic                 skip_next;
    logic                 disc_reg;
    logic                 disc_next;

    wire logic start;
    wire logic tested_bit;
    wire logic want_skip;
    wire logic [1:0] nop_count;
    wire logic is_test_op;
    wire logic test_ends;
    wire logic nop_ends;
    wire logic slot_free;
    wire logic [7:0] bit_hit;

    // ------------------------------------------------------------
    // instruction slot accounting
    // ------------------------------------------------------------
    assign is_test_op = dec.is_clear || dec.is_set;
    assign test_ends  = (state_reg == BTSE_TEST) && q4_now && !want_skip;
    assign nop_ends   = (state_reg == BTSE_NOP) && q4_now
                        && (nop_left_reg == 2'h1);
    // the word offered on a skipping test's last edge is the discarded
    // prefetch, so only a clean finish or the last nop frees the slot
    assign slot_free  = (state_reg == BTSE_IDLE) || test_ends || nop_ends;
    assign start      = q1_en && instr_valid && is_test_op && slot_free;

    // ------------------------------------------------------------
    // bit under test
    // ------------------------------------------------------------
    // one compare per bit position keeps the select a flat and-or tree
    for (genvar i = 0; i < 8; i++) begin : g_bit
        assign bit_hit[i] = (dec_reg.bit_sel == 3'(i)) && file_data[i];
    end
    assign tested_bit = |bit_hit;
    // clear variant skips on zero, set variant on one
    assign want_skip = (dec_reg.is_clear && !tested_bit)
                    || (dec_reg.is_set && tested_bit);
    // a two-word victim needs both its words flushed
    assign nop_count = next_two_word ? `BTSE_NOP_TWO_WORD
                                     : `BTSE_NOP_ONE_WORD;

    always_comb begin
        state_next    = state_reg;
        nop_left_next = nop_left_reg;
        cyc_next      = cyc_reg;
        skip_next     = 1'b0;
        disc_next     = 1'b0;
        unique case (state_reg)
            BTSE_IDLE: begin
                if (start) begin
                    state_next = BTSE_TEST;
                    cyc_next   = 2'h1;
                end
            end
            BTSE_TEST: begin
                if (q4_now) begin
                    if (want_skip) begin
                        state_next    = BTSE_NOP;
                        nop_left_next = nop_count;
                        skip_next     = 1'b1;
                        disc_next     = 1'b1;
                    end else if (start) begin
                        cyc_next   = 2'h1;         // back-to-back test
                    end else begin
                        state_next = BTSE_IDLE;
                    end
                end
            end
            BTSE_NOP: begin
                if (q4_now) begin
                    cyc_next      = cyc_reg + 2'h1;
                    nop_left_next = nop_left_reg - 2'h1;
                    if (nop_left_reg == 2'h1) begin
                        state_next = BTSE_IDLE;
                    end
                    if (start) begin
                        state_next = BTSE_TEST;
                        cyc_next   = 2'h1;
                    end
                end
            end
            default: state_next = BTSE_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) state_reg <= BTSE_IDLE;
        else       state_reg <= state_next;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) nop_left_reg <= 2'h0;
        else       nop_left_reg <= nop_left_next;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) cyc_reg <= 2'h0;
        else       cyc_reg <= cyc_next;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) skip_reg <= 1'b0;
        else       skip_reg <= skip_next;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) disc_reg <= 1'b0;
        else       disc_reg <= disc_next;
    end

    // operand fields are latched at the start of the test cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)      dec_reg <= '0;
        else if (start) dec_reg <= dec;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)      addr_reg <= '0;
        else if (start) addr_reg <= addr;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign file_addr        = addr_reg;
    assign file_rd          = (state_reg == BTSE_TEST);
    assign busy             = (state_reg != BTSE_IDLE);
    assign nop_cycle        = (state_reg == BTSE_NOP);
    assign discard_prefetch = disc_reg;
    assign skip_taken       = skip_reg;
    assign cycles_used      = cyc_reg;

endmodule : btse_exec
`default_nettype wire

// ---- logic/btse_map.svh ----
// btse_map.svh: encodings, field positions and cycle counts of the
// bit-test-skip execution block.
// assumes: included by bare name from the package and the design files.
`ifndef BTSE_MAP_SVH
`define BTSE_MAP_SVH

`define BTSE_OP_CLEAR       4'hb
`define BTSE_OP_SET         4'ha
`define BTSE_OP_MSB         15
`define BTSE_OP_LSB         12
`define BTSE_BIT_MSB        11
`define BTSE_BIT_LSB        9
`define BTSE_BANK_CTL_POS   8
`define BTSE_FILE_MSB       7
`define BTSE_FILE_LSB       0
`define BTSE_IDX_LIMIT      8'h5f
`define BTSE_Q_LAST         2'h3
`define BTSE_NOP_ONE_WORD   2'h1
`define BTSE_NOP_TWO_WORD   2'h2

`endif

// ---- logic/btse_pkg.sv ----
// btse_pkg.sv: types shared by the bit-test-skip execution block.
// assumes: btse_map.svh is on the include path.
`include "btse_map.svh"

package btse_pkg;

    // decoded instruction fields
    typedef struct packed {
        logic       is_clear;
        logic       is_set;
        logic [2:0] bit_sel;
        logic       bank_ctl;
        logic [7:0] file_addr;
    } btse_dec_t;

    // resolved operand address
    typedef enum logic [1:0] {
        BTSE_MODE_ACCESS,
        BTSE_MODE_BANKED,
        BTSE_MODE_INDEXED
    } btse_mode_t;

    typedef struct packed {
        btse_mode_t mode;
        logic [3:0] bank;
        logic [7:0] offset;
    } btse_addr_t;

endpackage : btse_pkg

// ---- verification/btse_exec_monitor.sv ----
// btse_exec_monitor.sv: assertions on the bit-test-skip sequencer ports.
// assumes: file_data and next_two_word are held through each test cycle.
`timescale 1ns/1ps
`default_nettype none
module btse_exec_monitor (
    input wire logic                 ref_clk,
    input wire logic                 nrst,
    input wire logic                 q1_en,
    input wire logic [15:0]          instr,
    input wire logic                 instr_valid,
    input wire logic [3:0]           bank_select_register,
    input wire logic                 ext_set_en,
    input wire logic [7:0]           file_data,
    input wire logic                 next_two_word,
    input wire btse_pkg::btse_addr_t file_addr,
    input wire logic                 file_rd,
    input wire logic                 busy,
    input wire logic                 discard_prefetch,
    input wire logic                 nop_cycle,
    input wire logic                 skip_taken,
    input wire logic [1:0]           cycles_used
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // starts inside a nop phase are taken only on the last nop's final edge, so they are left out here
    wire start = q1_en && instr_valid && !nop_cycle && instr[15:13] == 3'h5;
    wire want  = file_data[instr[11:9]] ^ instr[12];
    wire idx   = !instr[8] && ext_set_en && instr[7:0] <= 8'h5f;
    sequence s_skip_head;
        skip_taken && discard_prefetch && nop_cycle;
    endsequence
    sequence s_done(logic [1:0] n);
        !busy && cycles_used == n;
    endsequence
    a_start_read: assert property (start |=>
        file_rd && busy && cycles_used == 2'h1) else $error("no test start");
    a_mode_access: assert property (start && !instr[8] && !idx |=>
        file_addr.mode == btse_pkg::BTSE_MODE_ACCESS
        && file_addr.offset == $past(instr[7:0])) else $error("access mode");
    a_mode_banked: assert property (start && instr[8] |=>
        file_addr.mode == btse_pkg::BTSE_MODE_BANKED
        && file_addr.bank == $past(bank_select_register))
        else $error("banked mode");
    a_mode_indexed: assert property (start && idx |=>
        file_addr.mode == btse_pkg::BTSE_MODE_INDEXED)
        else $error("indexed mode");
    a_skip_taken: assert property (start && want |->
        ##5 s_skip_head ##1 !skip_taken) else $error("skip missing");
    a_skip_absent: assert property (start && !want |->
        ##5 !skip_taken && !nop_cycle) else $error("false skip");
    a_one_nop: assert property (start && want && !next_two_word |->
        ##5 nop_cycle[*4] ##1 s_done(2'h2)) else $error("one nop cycle");
    a_two_nop: assert property (start && want && next_two_word |->
        ##5 nop_cycle[*8] ##1 s_done(2'h3)) else $error("two nop cycles");
endmodule : btse_exec_monitor
bind btse_exec btse_exec_monitor i_btse_exec_monitor (.ref_clk, .nrst,
    .q1_en, .instr, .instr_valid, .bank_select_register, .ext_set_en,
    .file_data, .next_two_word, .file_addr, .file_rd, .busy,
    .discard_prefetch, .nop_cycle, .skip_taken, .cycles_used);
`default_nettype wire

// ---- verification/tb.sv ----
// tb.sv: self-checking bench for the bit-test-skip sequencer.
// assumes: package, design and monitor are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 ref_clk, nrst, q1_en, instr_valid, ext_set_en;
    logic                 next_two_word, file_rd, busy, discard_prefetch;
    logic                 nop_cycle, skip_taken;
    logic [15:0]          instr;
    logic [3:0]           bank_select_register;
    logic [7:0]           file_data;
    logic [1:0]           cycles_used;
    btse_pkg::btse_addr_t file_addr;
    int                   err_total, checked, cyc;

    btse_exec i_btse_exec (.ref_clk, .nrst, .q1_en, .instr, .instr_valid,
        .bank_select_register, .ext_set_en, .file_data, .next_two_word,
        .file_addr, .file_rd, .busy, .discard_prefetch, .nop_cycle,
        .skip_taken, .cycles_used);

    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk

    // one test word over four instruction cycles; inputs held throughout
    task automatic run(input logic [15:0] w, input logic [3:0] bank,
                       input logic ext, input logic [7:0] d, input logic two);
        logic                 op, skip;
        logic [1:0]           ncyc;
        btse_pkg::btse_mode_t mode;
        op = w[15:13] == 3'h5;
        skip = op && (d[w[11:9]] ^ w[12]);
        ncyc = skip ? (two ? 2'h3 : 2'h2) : 2'h1;
        mode = w[8] ? btse_pkg::BTSE_MODE_BANKED :
               (ext && w[7:0] <= 8'h5f) ? btse_pkg::BTSE_MODE_INDEXED :
               btse_pkg::BTSE_MODE_ACCESS;
        for (int k = 0; k < 16; k++) begin
            @(negedge ref_clk);
            if (k == 1)
                chk(file_rd === op && busy === op, "start");
            if (k == 1 && op)
                chk(file_addr.mode === mode, "mode");
            if (k == 1 && op)
                chk(file_addr.offset === w[7:0], "offset");
            if (k == 1 && op && w[8])
                chk(file_addr.bank === bank, "bank");
            // a skip shows on the edge after the q4 edge, four after start
            if (k == 5)
                chk(skip_taken === skip, "skip");
            if (k == 5)
                chk(discard_prefetch === skip, "discard");
            if (k == 5)
                chk(nop_cycle === skip && file_rd === 1'b0, "nop");
            if (k == 9 && op)
                chk(busy === (skip && two), "busy");
            if (k == 13 && op)
                chk(cycles_used === ncyc, "cycles");
            q1_en = k[1:0] == 2'h0;
            instr_valid = k == 0;
            instr = w;
            bank_select_register = bank;
            ext_set_en = ext;
            file_data = d;
            next_two_word = two;
        end
    endtask : run

    task automatic t_clear;
        run(16'hba20, 4'h0, 1'b0, 8'hdf, 1'b0);
        run(16'hba20, 4'h0, 1'b0, 8'h20, 1'b0);
    endtask : t_clear

    task automatic t_set;
        run(16'hae80, 4'h0, 1'b0, 8'h80, 1'b0);
        run(16'hae80, 4'h0, 1'b0, 8'h7f, 1'b0);
    endtask : t_set

    task automatic t_addr;
        run(16'hb15f, 4'h9, 1'b1, 8'h00, 1'b0);
        run(16'hb05f, 4'h9, 1'b1, 8'h01, 1'b0);
        run(16'hb060, 4'h9, 1'b1, 8'h01, 1'b0);
        run(16'hb05f, 4'h9, 1'b0, 8'h01, 1'b0);
    endtask : t_addr

    task automatic t_two_word;
        run(16'hb000, 4'h0, 1'b0, 8'h00, 1'b1);
        run(16'hb000, 4'h0, 1'b0, 8'h01, 1'b1);
        run(16'h9000, 4'h0, 1'b0, 8'h00, 1'b1);
    endtask : t_two_word

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // about 200 cycles are needed; the ceiling leaves ample margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            err_total++;
            report_and_stop();
        end
    end

    initial begin
        {nrst, q1_en, instr_valid, ext_set_en, next_two_word} = 5'h00;
        instr = 16'h0000;
        bank_select_register = 4'h0;
        file_data = 8'h00;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        t_clear();
        t_set();
        t_addr();
        t_two_word();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
